// ==== chip_ctrl_pkg.sv ====
// chip_ctrl_pkg: constants for chip mode, power and vector control
// assumes an axi4-lite master with 32-bit data and a 100 MHz bus clock
package chip_ctrl_pkg;
   // register byte offsets
   localparam logic [7:0] part_identifier_high_off = 8'h1a;
   localparam logic [7:0] part_identifier_low_off = 8'h1b;
   localparam logic [7:0] mode_reg_off = 8'h20;
   localparam logic [7:0] freeze_reg_off = 8'h24;
   localparam logic [7:0] vector_base_register_off = 8'h28;
   localparam logic [7:0] enable_reg_off = 8'h2c;
   localparam logic [7:0] status_reg_off = 8'h30;
   // part identifier fields, values arbitrary
   localparam logic [3:0] major_family = 4'h5;
   localparam logic [3:0] minor_family = 4'h2;
   localparam logic [3:0] major_mask = 4'h0;
   localparam logic [3:0] minor_mask = 4'h1;
   localparam int part_major_family_pos = 12;
   localparam int part_minor_family_pos = 8;
   localparam int part_major_mask_pos = 4;
   // reset values
   localparam logic [7:0] vector_base_reset = 8'hff;
   localparam logic [1:0] freeze_reset = 2'h0;
   localparam logic [5:0] enable_reset = 6'h00;
   // fixed and base-relative vectors
   localparam logic [15:0] vec_system_reset = 16'hfffe;
   localparam logic [15:0] vec_osc_monitor = 16'hfffc;
   localparam logic [15:0] vec_watchdog = 16'hfffa;
   localparam logic [7:0] vec_trap = 8'hf8;
   localparam logic [7:0] vec_software_trap = 8'hf6;
   localparam logic [7:0] vec_link_error = 8'hf4;
   localparam logic [7:0] vec_link_ext_error = 8'hf2;
   localparam logic [7:0] vec_tick = 8'hf0;
   localparam logic [7:0] vec_serial = 8'hd8;
   localparam logic [7:0] vec_lock = 8'hc6;
   localparam logic [7:0] vec_flash = 8'hb8;
   localparam logic [7:0] vec_spurious = 8'h80;
   // oscillator monitor timeout
   localparam int osc_timeout_ns = 1000;
   localparam int clk_period_ns = 10;
   localparam int osc_timeout_cycles = osc_timeout_ns / clk_period_ns;
   localparam logic [1:0] axi_okay = 2'b00;
   localparam logic [1:0] axi_slverr = 2'b10;
   typedef enum logic [1:0]
   {
      pwr_run = 2'b00,
      pwr_wait = 2'b01,
      pwr_stop = 2'b10
   } power_state_t;
endpackage : chip_ctrl_pkg

// ==== chip_ctrl.sv ====
// chip_ctrl: chip mode strap, low-power modes, freeze and interrupt vector selection
// assumes the core pulses stop/wait requests and acknowledges vectors with a one-cycle pulse
`timescale 1ns/1ps
module chip_ctrl
   import chip_ctrl_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic mode_select_strap_in,
   input wire logic stop_op_in,
   input wire logic idle_until_interrupt_op_in,
   input wire logic i_mask_in,
   input wire logic x_mask_in,
   input wire logic die_link_interrupt_in,
   input wire logic osc_clock_present_in,
   input wire logic osc_monitor_reset_in,
   input wire logic watchdog_reset_in,
   input wire logic illegal_access_in,
   input wire logic trap_req_in,
   input wire logic software_trap_instruction_in,
   input wire logic link_error_req_in,
   input wire logic link_ext_error_req_in,
   input wire logic tick_req_in,
   input wire logic serial_req_in,
   input wire logic lock_req_in,
   input wire logic flash_req_in,
   input wire logic vector_ack_in,
   output logic [15:0] vector_addr_out,
   output logic vector_valid_out,
   output logic normal_mode_out,
   output logic background_debug_block_out,
   output logic cpu_clock_enable_out,
   output logic stop_mode_out,
   output logic wait_mode_out,
   output logic watchdog_freeze_out,
   output logic tick_freeze_out,
   output logic system_reset_out
);
   // ************************************************************
   // state
   // ************************************************************
   power_state_t power_state;
   power_state_t next_power_state;
   logic mode_bit;
   logic strap_taken;
   logic [7:0] vector_base_register;
   logic [1:0] freeze_enable;
   logic [5:0] local_enable;
   logic [15:0] timeout_count;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   // ************************************************************
   // interrupt selection
   // ************************************************************
   wire logic clock_monitor_enable_bit = local_enable[0];
   wire logic die_link_error_enable = local_enable[1];
   wire logic tick_enable = local_enable[2];
   wire logic serial_enable = local_enable[3];
   wire logic lock_interrupt_enable = local_enable[4];
   wire logic flash_enable = local_enable[5];
   wire logic osc_timeout = clock_monitor_enable_bit
      && (timeout_count == 16'(osc_timeout_cycles));
   wire logic any_reset = illegal_access_in || watchdog_reset_in || osc_timeout
      || (osc_monitor_reset_in && clock_monitor_enable_bit);
   wire logic req_link_ext = link_ext_error_req_in && die_link_error_enable && !i_mask_in;
   wire logic req_tick = tick_req_in && tick_enable && !i_mask_in;
   wire logic req_serial = serial_req_in && serial_enable && !i_mask_in;
   wire logic req_lock = lock_req_in && lock_interrupt_enable && !i_mask_in;
   wire logic req_flash = flash_req_in && flash_enable && !i_mask_in;
   wire logic req_link_err = link_error_req_in && !x_mask_in;
   wire logic any_irq = trap_req_in || software_trap_instruction_in || req_link_err
      || req_link_ext || req_tick || req_serial || req_lock || req_flash;
   wire logic wake = any_irq || die_link_interrupt_in;
   // fixed then base-relative, in vector order
   wire logic [7:0] low_sel =
      trap_req_in ? vec_trap :
      software_trap_instruction_in ? vec_software_trap :
      req_link_err ? vec_link_error :
      req_link_ext ? vec_link_ext_error :
      req_tick ? vec_tick :
      req_serial ? vec_serial :
      req_lock ? vec_lock :
      req_flash ? vec_flash : vec_spurious;
   wire logic [15:0] next_vector =
      illegal_access_in ? vec_system_reset :
      (osc_timeout || osc_monitor_reset_in && clock_monitor_enable_bit) ? vec_osc_monitor :
      watchdog_reset_in ? vec_watchdog :
      {vector_base_register, low_sel};
   // ************************************************************
   // register bus decode
   // ************************************************************
   wire logic wr_fire = aw_held && w_held && !s_axi_bvalid;
   wire logic [15:0] part_id = {major_family, minor_family, major_mask, minor_mask};
   wire logic [7:0] rd_a = s_axi_araddr;
   wire logic rd_ok = rd_a == part_identifier_high_off || rd_a == part_identifier_low_off
      || rd_a == mode_reg_off || rd_a == freeze_reg_off || rd_a == vector_base_register_off
      || rd_a == enable_reg_off || rd_a == status_reg_off;
   wire logic [31:0] rd_val =
      (rd_a == part_identifier_high_off) ? {24'h0, part_id[15:8]} :
      (rd_a == part_identifier_low_off) ? {24'h0, part_id[7:0]} :
      (rd_a == mode_reg_off) ? {31'h0, mode_bit} :
      (rd_a == freeze_reg_off) ? {30'h0, freeze_enable} :
      (rd_a == vector_base_register_off) ? {24'h0, vector_base_register} :
      (rd_a == enable_reg_off) ? {26'h0, local_enable} :
      (rd_a == status_reg_off) ? {30'h0, power_state} : 32'h0;
   wire logic wr_ok = aw_addr == mode_reg_off || aw_addr == freeze_reg_off
      || aw_addr == vector_base_register_off || aw_addr == enable_reg_off;
   // ************************************************************
   // power state
   // ************************************************************
   always_comb
   begin
      next_power_state = power_state;
      unique case (power_state)
         pwr_run:
         begin
            if (stop_op_in)
               next_power_state = pwr_stop;
            else if (idle_until_interrupt_op_in)
               next_power_state = pwr_wait;
         end
         pwr_wait, pwr_stop:
         begin
            if (wake)
               next_power_state = pwr_run;
         end
         default:
            next_power_state = pwr_run;
      endcase
   end
   // ************************************************************
   // sequential logic
   // ************************************************************
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in || any_reset)
      begin
         power_state <= pwr_run;
         timeout_count <= 16'h0;
      end
      else
      begin
         power_state <= next_power_state;
         if (osc_clock_present_in || !clock_monitor_enable_bit)
            timeout_count <= 16'h0;
         else if (!osc_timeout)
            timeout_count <= timeout_count + 16'h1;
      end
   end
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         strap_taken <= 1'b0;
         mode_bit <= 1'b0;
         vector_base_register <= vector_base_reset;
         freeze_enable <= freeze_reset;
         local_enable <= enable_reset;
      end
      else
      begin
         strap_taken <= 1'b1;
         if (!strap_taken)
            mode_bit <= mode_select_strap_in;
         else if (wr_fire && aw_addr == mode_reg_off && w_strb[0] && w_data[0])
            mode_bit <= 1'b1;
         if (wr_fire && w_strb[0] && aw_addr == freeze_reg_off)
            freeze_enable <= w_data[1:0];
         if (wr_fire && w_strb[0] && aw_addr == vector_base_register_off)
            vector_base_register <= w_data[7:0];
         if (wr_fire && w_strb[0] && aw_addr == enable_reg_off)
            local_enable <= w_data[5:0];
      end
   end
   // axi write channel
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= axi_okay;
      end
      else
      begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? axi_okay : axi_slverr;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // axi read channel
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= axi_okay;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? axi_okay : axi_slverr;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
   // outputs
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         vector_addr_out <= vec_system_reset;
         vector_valid_out <= 1'b0;
         normal_mode_out <= 1'b0;
         background_debug_block_out <= 1'b0;
         cpu_clock_enable_out <= 1'b1;
         stop_mode_out <= 1'b0;
         wait_mode_out <= 1'b0;
         watchdog_freeze_out <= 1'b0;
         tick_freeze_out <= 1'b0;
         system_reset_out <= 1'b1;
      end
      else
      begin
         system_reset_out <= any_reset;
         vector_addr_out <= next_vector;
         vector_valid_out <= (any_irq || any_reset) && !vector_ack_in;
         normal_mode_out <= mode_bit;
         background_debug_block_out <= !mode_bit;
         cpu_clock_enable_out <= next_power_state == pwr_run;
         stop_mode_out <= next_power_state == pwr_stop;
         wait_mode_out <= next_power_state == pwr_wait;
         watchdog_freeze_out <= freeze_enable[0] && !mode_bit;
         tick_freeze_out <= freeze_enable[1] && !mode_bit;
      end
   end
   // ram is not held here and is never cleared on reset
   // clocking from locked loop or oscillator and flash timing are outside
   // ************************************************************
   // checks
   // ************************************************************
   a_stop_entry: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      power_state == pwr_run && stop_op_in && !any_reset |=> stop_mode_out && power_state == pwr_stop)
      else $error("stop not entered");
   a_wait_entry: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      power_state == pwr_run && !stop_op_in && idle_until_interrupt_op_in && !any_reset |=> wait_mode_out)
      else $error("wait not entered");
   a_wait_clock_off: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      wait_mode_out |-> !cpu_clock_enable_out)
      else $error("cpu clock running in wait");
   a_stop_exit: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      power_state == pwr_stop && die_link_interrupt_in |=> power_state == pwr_run && !stop_mode_out)
      else $error("stop not left on link interrupt");
   a_wait_exit: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      power_state == pwr_wait && any_irq |=> power_state == pwr_run)
      else $error("wait not ended by interrupt");
   a_strap_capture: assert property (@(posedge sys_clk_in)
      $rose(resetn_in) |=> ##1 mode_bit == $past(mode_select_strap_in, 2))
      else $error("strap not captured");
   a_mode_restricted: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      strap_taken && $past(strap_taken) && $past(mode_bit) |-> mode_bit)
      else $error("normal mode left by software");
   a_debug_mode: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      strap_taken |=> background_debug_block_out == !$past(mode_bit))
      else $error("debug state wrong");
   a_tick_priority: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      !any_reset && !trap_req_in && !software_trap_instruction_in && !req_link_err && !req_link_ext && req_tick
      |=> vector_addr_out == {$past(vector_base_register), vec_tick})
      else $error("tick vector wrong");
   a_fixed_vector: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      illegal_access_in |=> vector_addr_out == vec_system_reset && system_reset_out)
      else $error("system reset vector wrong");
   a_osc_timeout: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      osc_timeout |=> system_reset_out)
      else $error("monitor timeout without reset");
endmodule : chip_ctrl

// ==== core_model.sv ====
// core_model: processor core partner, acknowledges presented vectors
// assumes the bus clock and the active-low synchronous reset of the block
`timescale 1ns/1ps
module core_model
(
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic slow_in,
   input wire logic vector_valid_in,
   output logic vector_ack_out
);
   // ***************************
   // vector acknowledge
   // ***************************
   logic [2:0] wait_cnt;
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in || !vector_valid_in || vector_ack_out)
      begin
         wait_cnt <= 3'h0;
         vector_ack_out <= 1'b0;
      end
      else if (!slow_in || wait_cnt == 3'h4)
      begin
         vector_ack_out <= 1'b1;
      end
      else
      begin
         wait_cnt <= wait_cnt + 3'h1;
      end
   end
endmodule : core_model

// ==== tb_chip_ctrl.sv ====
// tb_chip_ctrl: self-checking bench for chip_ctrl with a reference model
// assumes chip_ctrl_pkg and core_model compiled before this file
`timescale 1ns/1ps
module tb_chip_ctrl;
   import chip_ctrl_pkg::*;
   // ***************************
   // stimulus signals
   // ***************************
   logic clk = 1'b0, rstn = 1'b0, strap = 1'b1, stop_op = 1'b0, wait_op = 1'b0;
   logic i_mask = 1'b0, x_mask = 1'b0, link_int = 1'b0, osc_ok = 1'b1, slow = 1'b0;
   logic [2:0] rst_src = 3'h0;
   logic [7:0] irq = 8'h00;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rd, rd2;
   logic ack_q = 1'b0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, ack, vvalid, nmode, dbg, cpu_en;
   logic stop_m, wait_m, wd_frz, tk_frz, sys_rst;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] vaddr;
   logic [5:0] en = 6'h00;
   logic [7:0] vb = 8'hff;
   logic [16:0] ev;
   int error_cnt = 0, comparisons = 0, seed = 32'h80a7, n;
   initial forever #5 clk = ~clk;
   // acknowledge as the design saw it at the last edge
   always @(posedge clk) ack_q <= ack;
   chip_ctrl dut (.sys_clk_in(clk), .resetn_in(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mode_select_strap_in(strap),
      .stop_op_in(stop_op), .idle_until_interrupt_op_in(wait_op), .i_mask_in(i_mask), .x_mask_in(x_mask),
      .die_link_interrupt_in(link_int), .osc_clock_present_in(osc_ok), .osc_monitor_reset_in(rst_src[1]),
      .watchdog_reset_in(rst_src[2]), .illegal_access_in(rst_src[0]), .trap_req_in(irq[0]),
      .software_trap_instruction_in(irq[1]), .link_error_req_in(irq[2]), .link_ext_error_req_in(irq[3]),
      .tick_req_in(irq[4]), .serial_req_in(irq[5]), .lock_req_in(irq[6]), .flash_req_in(irq[7]),
      .vector_ack_in(ack), .vector_addr_out(vaddr), .vector_valid_out(vvalid), .normal_mode_out(nmode),
      .background_debug_block_out(dbg), .cpu_clock_enable_out(cpu_en), .stop_mode_out(stop_m),
      .wait_mode_out(wait_m), .watchdog_freeze_out(wd_frz), .tick_freeze_out(tk_frz),
      .system_reset_out(sys_rst));
   core_model partner (.sys_clk_in(clk), .resetn_in(rstn), .slow_in(slow), .vector_valid_in(vvalid),
      .vector_ack_out(ack));
   // ***************************
   // checking and bus tasks
   // ***************************
   task automatic report_and_stop();
      $display("checks %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic timeout(input int cnt);
      if (cnt >= 200)
      begin
         error_cnt++;
         $display("[ERR] bus wait expired");
         report_and_stop();
      end
   endtask : timeout
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw_d, w_d;
      int c;
      aw_d = 0;
      w_d = 0;
      c = 0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      while (!(aw_d && w_d) && c < 200)
      begin
         @(posedge clk);
         c++;
         if (!aw_d && awready)
         begin
            aw_d = 1;
            awvalid <= 1'b0;
         end
         if (!w_d && wready)
         begin
            w_d = 1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         c++;
      end
      while (!bvalid && c < 200);
      timeout(c);
      chk("bresp", {30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      int c;
      c = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         c++;
      end
      while (!arready && c < 200);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         c++;
      end
      while (!rvalid && c < 200);
      timeout(c);
      d = rdata;
      chk("rresp", {30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
   endtask : axi_rd
   task automatic do_reset(input logic s);
      rstn <= 1'b0;
      strap <= s;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : do_reset
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step
   // reference vector selection: {valid, address}
   function automatic logic [16:0] ref_vec();
      logic [7:0] offs [8];
      logic [7:0] ok;
      offs = '{vec_trap, vec_software_trap, vec_link_error, vec_link_ext_error, vec_tick, vec_serial,
         vec_lock, vec_flash};
      ok = {{5{~i_mask}} & en[5:1], ~x_mask, 2'b11};
      if (rst_src[0]) return {1'b1, vec_system_reset};
      if (rst_src[1]) return {1'b1, vec_osc_monitor};
      if (rst_src[2]) return {1'b1, vec_watchdog};
      for (int k = 0; k < 8; k++)
         if (irq[k] && ok[k]) return {1'b1, vb, offs[k]};
      return 17'h0;
   endfunction : ref_vec
   // ***************************
   // main sequence
   // ***************************
   initial
   begin
      do_reset(1'b0);
      #1;
      chk("debug", {31'h0, dbg}, 32'h1);
      chk("normal", {31'h0, nmode}, 32'h0);
      axi_rd(part_identifier_high_off, rd, axi_okay);
      axi_rd(part_identifier_low_off, rd2, axi_okay);
      chk("part id", {16'h0, rd[7:0], rd2[7:0]}, {16'h0, major_family, minor_family, major_mask, minor_mask});
      axi_wr(part_identifier_low_off, 32'h0, axi_slverr);
      axi_rd(8'h40, rd, axi_slverr);
      chk("unmapped", rd, 32'h0);
      axi_rd(vector_base_register_off, rd, axi_okay);
      chk("base rst", rd, {24'h0, vector_base_reset});
      axi_rd(enable_reg_off, rd, axi_okay);
      chk("en rst", rd, {26'h0, enable_reset});
      axi_wr(freeze_reg_off, 32'h3, axi_okay);
      step(2);
      chk("freeze", {30'h0, wd_frz, tk_frz}, 32'h3);
      axi_wr(mode_reg_off, 32'h1, axi_okay);
      axi_wr(mode_reg_off, 32'h0, axi_okay);
      axi_rd(mode_reg_off, rd, axi_okay);
      step(2);
      chk("mode sw", {29'h0, rd[0], nmode, dbg}, 32'h6);
      chk("unfrozen", {30'h0, wd_frz, tk_frz}, 32'h0);
      do_reset(1'b1);
      #1;
      chk("normal rst", {30'h0, nmode, dbg}, 32'h2);
      // stop, woken by the die link; wait, held by a masked tick, woken by a trap
      stop_op <= 1'b1;
      @(posedge clk);
      stop_op <= 1'b0;
      step(2);
      chk("stop", {29'h0, stop_m, wait_m, cpu_en}, 32'h4);
      axi_rd(status_reg_off, rd, axi_okay);
      chk("status stop", rd, {30'h0, pwr_stop});
      link_int <= 1'b1;
      step(3);
      chk("stop exit", {29'h0, stop_m, wait_m, cpu_en}, 32'h1);
      link_int <= 1'b0;
      wait_op <= 1'b1;
      @(posedge clk);
      wait_op <= 1'b0;
      i_mask <= 1'b1;
      irq <= 8'h10;
      step(4);
      chk("wait", {29'h0, stop_m, wait_m, cpu_en}, 32'h2);
      axi_rd(status_reg_off, rd, axi_okay);
      chk("status wait", rd, {30'h0, pwr_wait});
      irq <= 8'h01;
      step(3);
      chk("wait exit", {29'h0, stop_m, wait_m, cpu_en}, 32'h1);
      // random requests against the reference priority model
      en = 6'h3f;
      axi_wr(enable_reg_off, {26'h0, en}, axi_okay);
      for (n = 0; n < 300; n++)
      begin
         if (n % 50 == 0)
         begin
            vb = $random(seed);
            axi_wr(vector_base_register_off, {24'h0, vb}, axi_okay);
            en = {$random(seed)} | 6'h01;
            axi_wr(enable_reg_off, {26'h0, en}, axi_okay);
         end
         rst_src <= ($random(seed) % 8 == 0) ? $random(seed) : 3'h0;
         irq <= $random(seed);
         i_mask <= $random(seed);
         x_mask <= $random(seed);
         slow <= $random(seed);
         step(2);
         ev = ref_vec();
         chk("vec valid", {31'h0, vvalid}, {31'h0, ev[16] && !ack_q});
         chk("sys reset", {31'h0, sys_rst}, {31'h0, |rst_src});
         if (ev[16])
            chk("vector", {16'h0, vaddr}, {16'h0, ev[15:0]});
      end
      rst_src <= 3'h0;
      irq <= 8'h00;
      osc_ok <= 1'b0;
      step(50);
      chk("osc early", {31'h0, sys_rst}, 32'h0);
      step(osc_timeout_cycles - 49);
      chk("osc timeout", {31'h0, sys_rst}, 32'h1);
      report_and_stop();
   end
endmodule : tb_chip_ctrl
